// ==== ebc_map.svh ====
// Constants of the external bus controller: encodings, reset values, counts
`ifndef EBC_MAP_SVH
`define EBC_MAP_SVH

// ==========================================================================
// Bus type encodings
`define EBC_BT_8_DEMUX      2'h0
`define EBC_BT_8_MUX        2'h1
`define EBC_BT_16_DEMUX     2'h2
`define EBC_BT_16_MUX       2'h3

// ==========================================================================
// Segment line select encodings
`define EBC_SAL_TWO         2'h3
`define EBC_SAL_SEVEN       2'h2
`define EBC_SAL_NONE        2'h1
`define EBC_SEG_TWO_MASK    7'h03
`define EBC_SEG_SEVEN_MASK  7'h7F

// ==========================================================================
// Reset values, field positions and window count
`define EBC_CFG_RESET       16'h0000
`define EBC_WIN_LSB         12
`define EBC_SEG_LSB         16
`define EBC_NUM_WIN         4

// ==========================================================================
// Timing counts in core clock cycles
`define EBC_ALE_CYCLES      1
`define EBC_ALE_EXT_CYCLES  1
`define EBC_RW_DLY_CYCLES   1

`endif

// ==== ebc_pkg.sv ====
// Types shared by the external bus controller
package ebc_pkg;

    typedef struct packed {
        logic [4:0] rsvd;
        logic       bus_active;
        logic       cs_use;
        logic [1:0] bus_type;
        logic       ale_ext;
        logic       rw_dly;
        logic [4:0] waits;
    } ebc_cfg_t;

    typedef struct packed {
        logic [11:0] base;
        logic [3:0]  size;
    } ebc_win_t;

    typedef struct packed {
        logic        write;
        logic        word;
        logic [23:0] addr;
        logic [15:0] wdata;
    } ebc_req_t;

    typedef struct packed {
        logic       seg_dis;
        logic [1:0] segment_line_select_field;
        logic [1:0] chip_select_count_field;
    } ebc_rstimg_t;

    typedef enum logic [5:0] {
        EBC_IDLE  = 6'h01,
        EBC_ALE   = 6'h02,
        EBC_LATCH = 6'h04,
        EBC_DLY   = 6'h08,
        EBC_CMD   = 6'h10,
        EBC_END   = 6'h20
    } ebc_state_t;

endpackage

// ==== ebc_ctrl.sv ====
// External bus controller: windows, reset configuration, bus cycle sequencer
`timescale 1ns/10ps
`include "ebc_map.svh"

module ebc_ctrl
    import ebc_pkg::*;
#(
    parameter int NUM_WIN = `EBC_NUM_WIN
) (
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                external_access_enable_pin,
    input  wire ebc_rstimg_t         reset_config_image,
    input  wire logic                default_bus_config_wr,
    input  wire ebc_cfg_t            default_bus_config_wdata,
    input  wire ebc_cfg_t [NUM_WIN-1:0] window_bus_config,
    input  wire ebc_win_t [NUM_WIN-1:0] window_address_select,
    input  wire logic                req_valid,
    input  wire ebc_req_t            req,
    output logic                     req_ready,
    output logic                     resp_valid,
    output logic [15:0]              resp_rdata,
    output logic                     illegal_bus_access_trap,
    output ebc_cfg_t                 default_bus_config,
    output logic                     single_chip_mode,
    output logic                     save_code_segment_pointer,
    output logic                     ale,
    output logic                     rd_n,
    output logic                     write_low_byte_strobe_n,
    input  wire logic [15:0]         multiplexed_data_port_in,
    output logic [15:0]              multiplexed_data_port_out,
    output logic [1:0]               multiplexed_data_port_oe,
    output logic [15:0]              separate_address_port,
    output logic                     separate_address_port_oe,
    output logic [6:0]               segment_port,
    output logic [NUM_WIN:0]         chip_sel_n
);

    // ======================================================================
    // Helpers
    function automatic logic win_hit(input logic [23:0] a, input ebc_win_t w);
        logic [11:0] m;
        m = 12'hFFF << w.size;
        return ((a[23:`EBC_WIN_LSB] ^ w.base) & m) == 12'h000;
    endfunction

    function automatic logic is_mux(input logic [1:0] bt);
        return bt == `EBC_BT_8_MUX || bt == `EBC_BT_16_MUX;
    endfunction

    function automatic logic is_wide(input logic [1:0] bt);
        return bt == `EBC_BT_16_DEMUX || bt == `EBC_BT_16_MUX;
    endfunction

    // ======================================================================
    // Reset configuration state
    ebc_cfg_t    dflt_reg,  dflt_next;
    ebc_rstimg_t img_reg,   img_next;
    logic        init_reg,  init_next;
    logic        scm_reg,   scm_next;
    logic        csp_reg,   csp_next;

    always_comb begin
        dflt_next = dflt_reg;
        img_next  = img_reg;
        init_next = 1'b1;
        scm_next  = scm_reg;
        csp_next  = csp_reg;
        if (!init_reg) begin
            // Straps are caught on the first edge after reset release
            img_next = reset_config_image;
            scm_next = external_access_enable_pin;
            csp_next = ~reset_config_image.seg_dis;
            if (!external_access_enable_pin) begin
                dflt_next.bus_active = 1'b1;
                dflt_next.bus_type   = multiplexed_data_port_in[1:0];
            end
        end else if (default_bus_config_wr) begin
            dflt_next = default_bus_config_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            dflt_reg <= `EBC_CFG_RESET;
            img_reg  <= '0;
            init_reg <= 1'b0;
            scm_reg  <= 1'b1;
            csp_reg  <= 1'b1;
        end else begin
            dflt_reg <= dflt_next;
            img_reg  <= img_next;
            init_reg <= init_next;
            scm_reg  <= scm_next;
            csp_reg  <= csp_next;
        end
    end

    // ======================================================================
    // Window selection
    ebc_cfg_t               sel_cfg;
    logic [NUM_WIN:0]       sel_cs;

    always_comb begin
        sel_cfg = dflt_reg;
        sel_cs  = (NUM_WIN+1)'(1);
        // Lowest window wins where windows overlap
        for (int i = NUM_WIN - 1; i >= 0; i--) begin
            if (window_bus_config[i].bus_active
                && win_hit(req.addr, window_address_select[i])) begin
                sel_cfg = window_bus_config[i];
                sel_cs  = '0;
                sel_cs[i+1] = 1'b1;
            end
        end
    end

    // ======================================================================
    // Bus cycle sequencer
    ebc_state_t       st_reg,    st_next;
    ebc_cfg_t         cfg_reg,   cfg_next;
    ebc_req_t         rq_reg,    rq_next;
    logic [4:0]       cnt_reg,   cnt_next;
    logic             rdy_reg,   rdy_next;
    logic             rv_reg,    rv_next;
    logic [15:0]      rd_reg,    rdat_next;
    logic             trap_reg,  trap_next;
    logic             ale_reg,   ale_next;
    logic             rdn_reg,   rdn_next;
    logic             wrn_reg,   wrn_next;
    logic [15:0]      dpo_reg,   dpo_next;
    logic [1:0]       dpe_reg,   dpe_next;
    logic [15:0]      sap_reg,   sap_next;
    logic             sae_reg,   sae_next;
    logic [6:0]       seg_reg,   seg_next;
    logic [NUM_WIN:0] csn_reg,   csn_next;
    logic [6:0]       seg_mask;

    always_comb begin
        case (img_reg.seg_dis ? 2'h0 : img_reg.segment_line_select_field)
            `EBC_SAL_TWO:   seg_mask = `EBC_SEG_TWO_MASK;
            `EBC_SAL_SEVEN: seg_mask = `EBC_SEG_SEVEN_MASK;
            default:        seg_mask = 7'h00;
        endcase
    end

    always_comb begin
        st_next   = st_reg;
        cfg_next  = cfg_reg;
        rq_next   = rq_reg;
        cnt_next  = cnt_reg;
        rdy_next  = rdy_reg;
        rv_next   = 1'b0;
        rdat_next = rd_reg;
        trap_next = 1'b0;
        ale_next  = ale_reg;
        rdn_next  = rdn_reg;
        wrn_next  = wrn_reg;
        dpo_next  = dpo_reg;
        dpe_next  = dpe_reg;
        sap_next  = sap_reg;
        sae_next  = sae_reg;
        seg_next  = seg_reg;
        csn_next  = csn_reg;
        case (st_reg)
            EBC_IDLE: begin
                if (req_valid && rdy_reg && init_reg) begin
                    rdy_next = 1'b0;
                    rq_next  = req;
                    cfg_next = sel_cfg;
                    if (!sel_cfg.bus_active) begin
                        trap_next = 1'b1;
                        rv_next   = 1'b1;
                        rdy_next  = 1'b1;
                    end else begin
                        st_next  = EBC_ALE;
                        cnt_next = sel_cfg.ale_ext ? 5'(`EBC_ALE_EXT_CYCLES) : 5'h00;
                        ale_next = 1'b1;
                        seg_next = req.addr[22:`EBC_SEG_LSB] & seg_mask;
                        csn_next = sel_cfg.cs_use ? ~sel_cs : '1;
                        if (is_mux(sel_cfg.bus_type)) begin
                            // Address overrides held write data at start
                            dpo_next = req.addr[15:0];
                            dpe_next = 2'h3;
                        end else begin
                            sap_next = req.addr[15:0];
                            sae_next = 1'b1;
                            dpe_next = 2'h0;
                        end
                    end
                end
            end
            EBC_ALE: begin
                if (cnt_reg == 5'h00) begin
                    ale_next = 1'b0;
                    st_next  = EBC_LATCH;
                end else begin
                    cnt_next = cnt_reg - 5'h01;
                end
            end
            EBC_LATCH: begin
                // Address removed only after the latch has closed
                if (is_mux(cfg_reg.bus_type)) begin
                    dpe_next = is_wide(cfg_reg.bus_type) ? 2'h0 : 2'h2;
                end
                st_next  = EBC_DLY;
                cnt_next = cfg_reg.rw_dly ? 5'(`EBC_RW_DLY_CYCLES) : 5'h00;
            end
            EBC_DLY: begin
                if (cnt_reg == 5'h00) begin
                    st_next = EBC_CMD;
                end else begin
                    cnt_next = cnt_reg - 5'h01;
                end
            end
            EBC_CMD: st_next = EBC_CMD;
            default: begin
                st_next = EBC_IDLE;
                rdy_next = 1'b1;
            end
        endcase
        if (st_next == EBC_CMD && st_reg != EBC_CMD) begin
            cnt_next = cfg_reg.waits;
            if (rq_reg.write) begin
                wrn_next = 1'b0;
                dpo_next = is_wide(cfg_reg.bus_type) ? rq_reg.wdata
                         : {dpo_reg[15:8], rq_reg.wdata[7:0]};
                dpe_next = is_wide(cfg_reg.bus_type) ? 2'h3
                         : {is_mux(cfg_reg.bus_type), 1'b1};
            end else begin
                rdn_next = 1'b0;
            end
        end
        if (st_reg == EBC_CMD) begin
            if (cnt_reg == 5'h00) begin
                st_next  = EBC_END;
                rdn_next = 1'b1;
                wrn_next = 1'b1;
                if (!rq_reg.write) begin
                    // Data sampled on the same edge that releases the strobe
                    rdat_next = is_wide(cfg_reg.bus_type) ? multiplexed_data_port_in
                              : {8'h00, multiplexed_data_port_in[7:0]};
                end
            end else begin
                cnt_next = cnt_reg - 5'h01;
            end
        end
        if (st_reg == EBC_END) begin
            rv_next  = 1'b1;
            csn_next = '1;
            if (!rq_reg.write) begin
                dpe_next = 2'h0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg   <= EBC_IDLE;
            cfg_reg  <= `EBC_CFG_RESET;
            rq_reg   <= '0;
            cnt_reg  <= 5'h00;
            rdy_reg  <= 1'b1;
            rv_reg   <= 1'b0;
            rd_reg   <= 16'h0000;
            trap_reg <= 1'b0;
            ale_reg  <= 1'b0;
            rdn_reg  <= 1'b1;
            wrn_reg  <= 1'b1;
            dpo_reg  <= 16'h0000;
            dpe_reg  <= 2'h0;
            sap_reg  <= 16'h0000;
            sae_reg  <= 1'b0;
            seg_reg  <= 7'h00;
            csn_reg  <= '1;
        end else begin
            st_reg   <= st_next;
            cfg_reg  <= cfg_next;
            rq_reg   <= rq_next;
            cnt_reg  <= cnt_next;
            rdy_reg  <= rdy_next;
            rv_reg   <= rv_next;
            rd_reg   <= rdat_next;
            trap_reg <= trap_next;
            ale_reg  <= ale_next;
            rdn_reg  <= rdn_next;
            wrn_reg  <= wrn_next;
            dpo_reg  <= dpo_next;
            dpe_reg  <= dpe_next;
            sap_reg  <= sap_next;
            sae_reg  <= sae_next;
            seg_reg  <= seg_next;
            csn_reg  <= csn_next;
        end
    end

    // ======================================================================
    // Outputs
    assign req_ready                  = rdy_reg;
    assign resp_valid                 = rv_reg;
    assign resp_rdata                 = rd_reg;
    assign illegal_bus_access_trap    = trap_reg;
    assign default_bus_config         = dflt_reg;
    assign single_chip_mode           = scm_reg;
    assign save_code_segment_pointer  = csp_reg;
    assign ale                        = ale_reg;
    assign rd_n                       = rdn_reg;
    assign write_low_byte_strobe_n    = wrn_reg;
    assign multiplexed_data_port_out  = dpo_reg;
    assign multiplexed_data_port_oe   = dpe_reg;
    assign separate_address_port      = sap_reg;
    assign separate_address_port_oe   = sae_reg;
    assign segment_port               = seg_reg;
    assign chip_sel_n                 = csn_reg;
endmodule

// ==== ebc_ctrl_props.sv ====
// Checker for bus cycle ordering and response timing of the bus controller
`timescale 1ns/10ps
module ebc_ctrl_props (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic        ale,
    input wire logic        rd_n,
    input wire logic        write_low_byte_strobe_n,
    input wire logic [15:0] multiplexed_data_port_out,
    input wire logic [1:0]  multiplexed_data_port_oe,
    input wire logic        separate_address_port_oe,
    input wire logic        resp_valid,
    input wire logic        illegal_bus_access_trap
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // ====================
    // Cycle phases
    sequence s_addr_phase;
        (rd_n && write_low_byte_strobe_n)[*3];
    endsequence
    sequence s_wdata_held;
        (multiplexed_data_port_oe[0] && $stable(multiplexed_data_port_out))[*2];
    endsequence
    AST_ADDR_BEFORE_CMD: assert property ($rose(ale) |-> s_addr_phase)
        else $error("strobe active during address phase");
    AST_ALE_SHORT: assert property ($rose(ale) |=> ##[0:1] !ale)
        else $error("latch enable too long");
    AST_ONE_STROBE: assert property (!(!rd_n && !write_low_byte_strobe_n))
        else $error("read and write strobes together");
    AST_WR_DRIVES: assert property (!write_low_byte_strobe_n |-> multiplexed_data_port_oe[0])
        else $error("write data not driven under strobe");
    AST_RD_RELEASED: assert property (!rd_n |-> !multiplexed_data_port_oe[0])
        else $error("data port driven during read");
    AST_WR_HOLD: assert property ($rose(write_low_byte_strobe_n) |-> s_wdata_held)
        else $error("write data not held after strobe");
    AST_RD_DONE: assert property ($rose(rd_n) |=> resp_valid)
        else $error("no response after read strobe");
    AST_DEMUX_ADDR: assert property ($rose(ale) && !multiplexed_data_port_oe[0]
        |-> separate_address_port_oe)
        else $error("address port not driven in demux cycle");
    AST_TRAP_NO_CYCLE: assert property (illegal_bus_access_trap
        |-> resp_valid && !ale && !$past(ale) && rd_n)
        else $error("trap without response or with bus cycle");
    AST_RESP_PULSE: assert property (resp_valid |=> !resp_valid)
        else $error("response longer than one cycle");
    AST_ADDR_OFF: assert property ($fell(rd_n) |-> !$past(multiplexed_data_port_oe[0]))
        else $error("address still driven as read strobe falls");
endmodule

bind ebc_ctrl ebc_ctrl_props u_props (
    .core_clk(core_clk), .rstn(rstn), .ale(ale), .rd_n(rd_n),
    .write_low_byte_strobe_n(write_low_byte_strobe_n),
    .multiplexed_data_port_out(multiplexed_data_port_out),
    .multiplexed_data_port_oe(multiplexed_data_port_oe),
    .separate_address_port_oe(separate_address_port_oe),
    .resp_valid(resp_valid), .illegal_bus_access_trap(illegal_bus_access_trap)
);

// ==== ebc_mem_model.sv ====
// Behavioural external memory with its address latch
`timescale 1ns/10ps
module ebc_mem_model (
    input  wire logic        core_clk,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        ale,
    input  wire logic [15:0] port_out,
    input  wire logic [1:0]  port_oe,
    input  wire logic [15:0] sep_addr,
    input  wire logic [1:0]  acc_cyc,
    output logic      [15:0] dq
);
    logic [15:0] mem [256];
    logic [15:0] lat  = 16'h0000;
    logic [15:0] junk = 16'h5A5A;
    logic [1:0]  cnt  = 2'h0;
    // ====================
    // Latch and storage
    always @(negedge ale) lat <= |port_oe ? port_out : sep_addr;
    always @(posedge wr_n) mem[lat[7:0]] <= port_out;
    always @(posedge core_clk) begin
        junk <= ~junk;
        cnt <= rd_n ? 2'h0 : (cnt == 2'h3 ? cnt : cnt + 2'h1);
    end
    // Released bus toggles so a stale value cannot pass
    assign dq = (!rd_n && cnt >= acc_cyc) ? mem[lat[7:0]] : junk;
endmodule

// ==== ebc_ctrl_tb.sv ====
// Self-checking bench for the external bus controller
`timescale 1ns/10ps
module ebc_ctrl_tb;
    import ebc_pkg::*;
    logic           core_clk, rstn, pin, cfg_wr, req_valid, strap_en, t_trap;
    logic           req_ready, resp_valid, trap, scm, save_csp, ale, rd_n, wr_n, sa_oe;
    ebc_rstimg_t    img;
    ebc_cfg_t       cfg_wd, dcfg;
    ebc_cfg_t [3:0] wcfg;
    ebc_win_t [3:0] wsel;
    ebc_req_t       req;
    logic [15:0]    rdata, p_in, p_out, sa, dq, r, sa_cap;
    logic [15:0]    lfsr = 16'hAA4D;
    logic [1:0]     p_oe, acc, strap_bt;
    logic [6:0]     seg, seg_cap, seg_mask;
    logic [4:0]     cs_n, cs_cap;
    int             n_mismatch = 0, n_compared = 0, cyc = 0, lat, k;

    assign p_in = strap_en ? {14'h0000, strap_bt}
        : {p_oe[1] ? p_out[15:8] : dq[15:8], p_oe[0] ? p_out[7:0] : dq[7:0]};

    ebc_ctrl dut_u (.core_clk(core_clk), .rstn(rstn), .external_access_enable_pin(pin),
        .reset_config_image(img), .default_bus_config_wr(cfg_wr),
        .default_bus_config_wdata(cfg_wd), .window_bus_config(wcfg),
        .window_address_select(wsel), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .resp_valid(resp_valid), .resp_rdata(rdata),
        .illegal_bus_access_trap(trap), .default_bus_config(dcfg),
        .single_chip_mode(scm), .save_code_segment_pointer(save_csp), .ale(ale),
        .rd_n(rd_n), .write_low_byte_strobe_n(wr_n), .multiplexed_data_port_in(p_in),
        .multiplexed_data_port_out(p_out), .multiplexed_data_port_oe(p_oe),
        .separate_address_port(sa), .separate_address_port_oe(sa_oe),
        .segment_port(seg), .chip_sel_n(cs_n));
    ebc_mem_model mem_u (.core_clk(core_clk), .rd_n(rd_n), .wr_n(wr_n), .ale(ale),
        .port_out(p_out), .port_oe(p_oe), .sep_addr(sa), .acc_cyc(acc), .dq(dq));

    // ====================
    // Helpers
    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            stop_test();
        end
    end
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    function automatic ebc_cfg_t mk(logic [1:0] bt, logic [6:0] t);
        return '{5'h00, 1'h1, 1'h1, bt, t[6], t[5], t[4:0]};
    endfunction
    function automatic logic [15:0] exp_lat(ebc_cfg_t c);
        return 16'(6 + c.ale_ext + c.rw_dly + c.waits);
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic do_reset(input logic p, input logic sd, input logic [1:0] bt);
        rstn = 1'h0;
        pin = p;
        img = '{sd, 2'h3, 2'h0};
        strap_bt = bt;
        strap_en = 1'h1;
        repeat (6) @(negedge core_clk);
        rstn = 1'h1;
        repeat (3) @(negedge core_clk);
        strap_en = 1'h0;
    endtask
    task automatic xfer(input logic w, input logic [23:0] a, input logic [15:0] d);
        logic rdy;
        @(negedge core_clk);
        req = '{w, 1'h1, a, d};
        req_valid = 1'h1;
        do begin
            rdy = req_ready;
            @(negedge core_clk);
        end while (!rdy);
        req_valid = 1'h0;
        lat = 1;
        while (!resp_valid && lat < 64) begin
            if (ale) {seg_cap, cs_cap, sa_cap} = {seg, cs_n, sa};
            @(negedge core_clk);
            lat++;
        end
        t_trap = trap;
    endtask
    task automatic rt(input logic [23:0] a, input ebc_cfg_t c);
        logic [15:0] d;
        logic [4:0]  cs_e;
        d = rnd();
        // Window k is placed at address nibble k+1; anything else is default
        cs_e = (a[23:20] >= 4'h1 && a[23:20] <= 4'h4) ? ~(5'h01 << a[23:20]) : 5'h1E;
        xfer(1'h1, a, d);
        chk("wlat", exp_lat(c), 16'(lat));
        xfer(1'h0, a, 16'h0000);
        chk("rlat", exp_lat(c), 16'(lat));
        chk("trap", 16'h0000, {15'h0000, t_trap});
        chk("rdata", c.bus_type[1] ? d : {8'h00, d[7:0]}, rdata);
        chk("seg", {9'h000, a[22:16] & seg_mask}, {9'h000, seg_cap});
        chk("cs", {11'h000, c.cs_use ? cs_e : 5'h1F}, {11'h000, cs_cap});
        if (!c.bus_type[0]) begin
            chk("sa", a[15:0], sa_cap);
            chk("sa_oe", 16'h0001, {15'h0000, sa_oe});
        end
    endtask

    // ====================
    // Scenarios
    initial begin
        {req_valid, cfg_wr, acc} = '0;
        {cfg_wd, req, wcfg, wsel} = '0;
        do_reset(1'h1, 1'h0, 2'h0);
        seg_mask = 7'h03;
        chk("scm", 16'h0001, {15'h0000, scm});
        chk("dcfg", 16'h0000, dcfg);
        chk("csp", 16'h0001, {15'h0000, save_csp});
        xfer(1'h0, 24'h010010, 16'h0000);
        chk("trap", 16'h0001, {15'h0000, t_trap});
        chk("tlat", 16'h0001, 16'(lat));
        cfg_wd = mk(2'h3, 7'h00);
        @(negedge core_clk) cfg_wr = 1'h1;
        @(negedge core_clk) cfg_wr = 1'h0;
        chk("dcfg", cfg_wd, dcfg);
        rt(24'h030020, cfg_wd);
        for (int i = 0; i < 16; i++) begin
            k = i % 4;
            r = rnd();
            wsel[k] = '{{4'(k + 1), 8'h00}, 4'h8};
            wcfg[k] = mk(2'(k), {r[6:5], 3'h0, r[1:0]});
            acc = r[1:0];
            rt({4'(k + 1), r[11:8], rnd()}, wcfg[k]);
        end
        acc = 2'h0;
        rt(24'h900044, cfg_wd);
        do_reset(1'h0, 1'h1, 2'h2);
        seg_mask = 7'h00;
        chk("scm", 16'h0000, {15'h0000, scm});
        chk("dcfg", 16'h0500, dcfg);
        chk("csp", 16'h0000, {15'h0000, save_csp});
        rt(24'h950040, ebc_cfg_t'(16'h0500));
        stop_test();
    end
endmodule
